// >>> external_data_move_cycle_timing.sv
// machine cycle sequencer with stretchable external data move and dual pointers
`timescale 1ns/10ps

// Operation
// - every machine cycle lasts exactly four clock periods, one per state
// - states run state_one, state_two, state_three, state_four in that order
// - only the rising clock edge used internally; near 50% duty recommended
// - one opcode fetched per instruction, at the end of its last machine cycle; length usually equals byte count
// - half of all opcodes execute in a single machine cycle
// - cycle count comes from the decoded opcode, not from byte length
// - other instructions last one to five machine cycles
// - external data move lasts two to nine machine cycles
// - read or write strobe lasts four clocks per added cycle, two clocks with no added cycle
// - external data moves target off-chip memory and mapped peripherals alike
// - indirect form takes address low byte from chosen bank register
// - indirect form takes address high byte from the port 2 latch
// - pointer form uses the full 16 bits of the selected data pointer
// - pointer select flag is bit 0 of register at 86h
// - other bits of pointer select register have no effect, read zero
// - flag 0 selects first data pointer, flag 1 the second
// - three-bit stretch field; external data move lasts stretch plus two
// - stretch is one after reset, giving three machine cycles
module external_data_move_cycle_timing (
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    // instruction issue from the fetch and decode unit
    input  wire logic                          instr_valid,
    input  wire logic [7:0]                    opcode,
    input  wire logic [3:0]                    decoded_cycles,
    input  wire logic [7:0]                    indirect_index_register,
    input  wire logic [7:0]                    port2_latch,
    input  wire logic [15:0]                   first_data_pointer,
    input  wire logic [15:0]                   second_data_pointer,
    // special function register access
    input  wire logic [7:0]                    sfr_addr,
    input  wire logic [7:0]                    sfr_wdata,
    input  wire logic                          sfr_wr,
    input  wire logic                          sfr_inc,
    output logic [7:0]                         sfr_rdata,
    // sequencing status
    output external_data_move_timing_pkg::mc_state_e         mc_state,
    output logic                               instr_taken,
    output logic [3:0]                         instr_cycles,
    output logic                               pointer_select_flag,
    // external data bus control
    output logic [15:0]                        ext_addr,
    output logic                               ext_rd_n,
    output logic                               ext_wr_n
);
    import external_data_move_timing_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    mc_state_e   state_ff,     nxt_state;
    logic [3:0]  mc_idx_ff,    nxt_mc_idx;
    logic [3:0]  len_ff,       nxt_len;
    logic        taken_ff,     nxt_taken;
    logic        is_read_ff,   nxt_is_read;
    logic        is_write_ff,  nxt_is_write;
    logic [15:0] addr_ff,      nxt_addr;
    logic        rd_n_ff,      nxt_rd_n;
    logic        wr_n_ff,      nxt_wr_n;
    logic        dps_ff,       nxt_dps;
    logic [2:0]  stretch_ff,   nxt_stretch;
    logic [7:0]  rdata_ff,     nxt_rdata;

    // ****************************************************************
    // opcode decode
    // ****************************************************************
    logic        op_read;
    logic        op_write;
    logic        op_pointer;
    logic [3:0]  op_len;
    logic [15:0] sel_pointer;
    logic        last_cycle;
    logic [5:0]  access_clk;
    logic        strobe_on;
    logic [5:0]  strobe_lo;
    logic [5:0]  strobe_hi;

    always_comb begin
        op_read    = (opcode == OP_READ_POINTER) || (opcode == OP_READ_INDIR0)
                     || (opcode == OP_READ_INDIR1);
        op_write   = (opcode == OP_WRITE_POINTER) || (opcode == OP_WRITE_INDIR0)
                     || (opcode == OP_WRITE_INDIR1);
        op_pointer = (opcode == OP_READ_POINTER) || (opcode == OP_WRITE_POINTER);
        // pointer choice follows the select flag
        sel_pointer = dps_ff ? second_data_pointer : first_data_pointer;
        if (op_read || op_write) begin
            op_len = EXTERNAL_DATA_MOVE_BASE_CYCLES + {1'b0, stretch_ff};
        end else if (decoded_cycles < MIN_CYCLES) begin
            op_len = MIN_CYCLES;
        end else if (decoded_cycles > MAX_PLAIN_CYCLES) begin
            op_len = MAX_PLAIN_CYCLES;
        end else begin
            op_len = decoded_cycles;
        end
        last_cycle = (mc_idx_ff == len_ff - MIN_CYCLES);
    end

    // ****************************************************************
    // machine cycle sequencing
    // ****************************************************************
    always_comb begin
        nxt_state    = state_ff;
        nxt_mc_idx   = mc_idx_ff;
        nxt_len      = len_ff;
        nxt_taken    = 1'b0;
        nxt_is_read  = is_read_ff;
        nxt_is_write = is_write_ff;
        nxt_addr     = addr_ff;
        // one clock per state, states in fixed order
        case (state_ff)
            STATE_ONE: begin
                nxt_state = STATE_TWO;
            end
            STATE_TWO: begin
                nxt_state = STATE_THREE;
            end
            STATE_THREE: begin
                nxt_state = STATE_FOUR;
            end
            default: begin
                nxt_state = STATE_ONE;
                if (last_cycle) begin
                    nxt_mc_idx   = 4'h0;
                    nxt_is_read  = 1'b0;
                    nxt_is_write = 1'b0;
                    nxt_len      = MIN_CYCLES;
                    // next opcode fetched only at the boundary that ends the last machine cycle
                    if (instr_valid) begin
                        nxt_taken    = 1'b1;
                        nxt_len      = op_len;
                        nxt_is_read  = op_read;
                        nxt_is_write = op_write;
                        if (op_pointer) begin
                            nxt_addr = sel_pointer;
                        end else if (op_read || op_write) begin
                            nxt_addr = {port2_latch, indirect_index_register};
                        end
                    end
                end else begin
                    nxt_mc_idx = mc_idx_ff + 4'h1;
                end
            end
        endcase
    end

    // ****************************************************************
    // read and write strobes
    // ****************************************************************
    always_comb begin
        // clocks elapsed since state_one of the first access cycle
        access_clk = 6'h0;
        if (nxt_mc_idx != 4'h0) begin
            access_clk = {nxt_mc_idx - 4'h1, 2'b00} + {4'h0, nxt_state};
        end
        // all register updates happen on the rising edge; strobe
        // edges fall on whole-state boundaries for this reason
        if (stretch_ff == 3'h0) begin
            strobe_lo = STROBE_START_FAST;
            strobe_hi = STROBE_START_FAST + STROBE_WIDTH_FAST;
        end else begin
            strobe_lo = STROBE_START;
            strobe_hi = STROBE_START + STROBE_PER_STEP * {3'h0, stretch_ff};
        end
        strobe_on = (nxt_mc_idx != 4'h0) && (access_clk >= strobe_lo)
                    && (access_clk < strobe_hi);
        nxt_rd_n  = ~(strobe_on && nxt_is_read);
        nxt_wr_n  = ~(strobe_on && nxt_is_write);
    end

    // ****************************************************************
    // special function registers
    // ****************************************************************
    always_comb begin
        nxt_dps     = dps_ff;
        nxt_stretch = stretch_ff;
        nxt_rdata   = 8'h00;
        if (sfr_inc && (sfr_addr == DATA_POINTER_SELECT_ADDR)) begin
            // increment flips the flag only; upper bits stay zero
            nxt_dps = ~dps_ff;
        end else if (sfr_wr && (sfr_addr == DATA_POINTER_SELECT_ADDR)) begin
            nxt_dps = sfr_wdata[POINTER_SELECT_FLAG_BIT];
        end else if (sfr_wr && (sfr_addr == CLOCK_CONTROL_REGISTER_ADDR)) begin
            nxt_stretch = sfr_wdata[STRETCH_FIELD_LSB +: STRETCH_FIELD_WIDTH];
        end
        if (sfr_addr == DATA_POINTER_SELECT_ADDR) begin
            nxt_rdata[POINTER_SELECT_FLAG_BIT] = nxt_dps;
        end else if (sfr_addr == CLOCK_CONTROL_REGISTER_ADDR) begin
            nxt_rdata[STRETCH_FIELD_LSB +: STRETCH_FIELD_WIDTH] = nxt_stretch;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff    <= STATE_ONE;
            mc_idx_ff   <= 4'h0;
            len_ff      <= MIN_CYCLES;
            taken_ff    <= 1'b0;
            is_read_ff  <= 1'b0;
            is_write_ff <= 1'b0;
            addr_ff     <= 16'h0000;
            rd_n_ff     <= 1'b1;
            wr_n_ff     <= 1'b1;
            dps_ff      <= POINTER_SELECT_RESET;
            stretch_ff  <= STRETCH_RESET;
            rdata_ff    <= 8'h00;
        end else begin
            state_ff    <= nxt_state;
            mc_idx_ff   <= nxt_mc_idx;
            len_ff      <= nxt_len;
            taken_ff    <= nxt_taken;
            is_read_ff  <= nxt_is_read;
            is_write_ff <= nxt_is_write;
            addr_ff     <= nxt_addr;
            rd_n_ff     <= nxt_rd_n;
            wr_n_ff     <= nxt_wr_n;
            dps_ff      <= nxt_dps;
            stretch_ff  <= nxt_stretch;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign mc_state            = state_ff;
    assign instr_taken         = taken_ff;
    assign instr_cycles        = len_ff;
    assign pointer_select_flag = dps_ff;
    assign ext_addr            = addr_ff;
    assign ext_rd_n            = rd_n_ff;
    assign ext_wr_n            = wr_n_ff;
    assign sfr_rdata           = rdata_ff;

endmodule

// >>> external_data_move_timing_pkg.sv
// constants and types shared by the external data move sequencer
package external_data_move_timing_pkg;

    // ****************************************************************
    // machine cycle states
    // ****************************************************************
    typedef enum logic [1:0] {
        STATE_ONE,
        STATE_TWO,
        STATE_THREE,
        STATE_FOUR
    } mc_state_e;

    localparam int unsigned STATES_PER_CYCLE = 4;

    // ****************************************************************
    // special function register map
    // ****************************************************************
    localparam logic [7:0] DATA_POINTER_SELECT_ADDR    = 8'h86;
    localparam logic [7:0] CLOCK_CONTROL_REGISTER_ADDR = 8'h9F;
    localparam int unsigned POINTER_SELECT_FLAG_BIT    = 0;
    localparam int unsigned STRETCH_FIELD_LSB          = 0;
    localparam int unsigned STRETCH_FIELD_WIDTH        = 3;
    localparam logic [2:0]  STRETCH_RESET              = 3'h1;
    localparam logic        POINTER_SELECT_RESET       = 1'b0;

    // ****************************************************************
    // instruction timing
    // ****************************************************************
    localparam logic [3:0] MIN_CYCLES       = 4'h1;
    localparam logic [3:0] MAX_PLAIN_CYCLES = 4'h5;
    localparam logic [3:0] EXTERNAL_DATA_MOVE_BASE_CYCLES = 4'h2;
    // strobe timing in clocks counted from state_one of the first access cycle
    localparam logic [5:0] STROBE_START_FAST = 6'h01;
    localparam logic [5:0] STROBE_WIDTH_FAST = 6'h02;
    localparam logic [5:0] STROBE_START      = 6'h02;
    localparam logic [5:0] STROBE_PER_STEP   = 6'h04;

    // ****************************************************************
    // external data move opcodes
    // ****************************************************************
    localparam logic [7:0] OP_READ_POINTER   = 8'hE0;
    localparam logic [7:0] OP_READ_INDIR0    = 8'hE2;
    localparam logic [7:0] OP_READ_INDIR1    = 8'hE3;
    localparam logic [7:0] OP_WRITE_POINTER  = 8'hF0;
    localparam logic [7:0] OP_WRITE_INDIR0   = 8'hF2;
    localparam logic [7:0] OP_WRITE_INDIR1   = 8'hF3;

endpackage

// >>> external_data_move_cycle_timing_checker.sv
// assertion checker for the machine cycle sequencer
`timescale 1ns/10ps
module external_data_move_cycle_timing_checker
    import external_data_move_timing_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        instr_valid,
    input wire logic [7:0]  opcode,
    input wire logic [3:0]  decoded_cycles,
    input wire logic [7:0]  indirect_index_register,
    input wire logic [7:0]  port2_latch,
    input wire logic [15:0] first_data_pointer,
    input wire logic [15:0] second_data_pointer,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_inc,
    input mc_state_e        mc_state,
    input wire logic        instr_taken,
    input wire logic [3:0]  instr_cycles,
    input wire logic        pointer_select_flag,
    input wire logic [15:0] ext_addr,
    input wire logic        ext_rd_n,
    input wire logic        ext_wr_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire logic mv_op = opcode inside {OP_READ_POINTER, OP_READ_INDIR0, OP_READ_INDIR1,
        OP_WRITE_POINTER, OP_WRITE_INDIR0, OP_WRITE_INDIR1};
    chk_state_step: assert property (
        !$past(srst) |-> (mc_state - $past(mc_state)) == 2'h1) else $error("state skipped");
    chk_taken_cause: assert property (
        instr_taken |-> mc_state == STATE_ONE && $past(mc_state) == STATE_FOUR
        && $past(instr_valid)) else $error("issue at wrong edge");
    chk_plain_len: assert property (
        instr_taken && !$past(mv_op) && $past(decoded_cycles) inside {[1:5]}
        |-> instr_cycles == $past(decoded_cycles)) else $error("plain length wrong");
    chk_move_len: assert property (
        instr_taken && $past(mv_op) |-> instr_cycles inside {[2:9]})
        else $error("move length out of range");
    chk_ptr_addr: assert property (
        instr_taken && $past(mv_op) && !$past(opcode[1]) |-> ext_addr == ($past(
        pointer_select_flag) ? $past(second_data_pointer) : $past(first_data_pointer)))
        else $error("pointer address wrong");
    chk_indir_addr: assert property (
        instr_taken && $past(mv_op) && $past(opcode[1])
        |-> ext_addr == {$past(port2_latch), $past(indirect_index_register)})
        else $error("indirect address wrong");
    chk_strobe_start: assert property (
        $fell(ext_rd_n) || $fell(ext_wr_n) |-> mc_state inside {STATE_TWO, STATE_THREE}
        ##1 !(ext_rd_n && ext_wr_n)) else $error("strobe start wrong");
    chk_flag_toggle: assert property (
        sfr_inc && sfr_addr == DATA_POINTER_SELECT_ADDR
        |=> pointer_select_flag != $past(pointer_select_flag)) else $error("flag not toggled");
endmodule
bind external_data_move_cycle_timing external_data_move_cycle_timing_checker u_external_data_move_cycle_timing_checker (
    .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .opcode(opcode),
    .decoded_cycles(decoded_cycles), .indirect_index_register(indirect_index_register),
    .port2_latch(port2_latch), .first_data_pointer(first_data_pointer),
    .second_data_pointer(second_data_pointer), .sfr_addr(sfr_addr), .sfr_inc(sfr_inc),
    .mc_state(mc_state), .instr_taken(instr_taken), .instr_cycles(instr_cycles),
    .pointer_select_flag(pointer_select_flag), .ext_addr(ext_addr),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));

// >>> ext_mem.sv
// external data space model: counts strobe clocks, logs the address seen
`timescale 1ns/10ps
module ext_mem (
    input wire logic        clk_sys,
    input wire logic [15:0] ext_addr,
    input wire logic        ext_rd_n,
    input wire logic        ext_wr_n
);
    int unsigned rd_low = 0;
    int unsigned wr_low = 0;
    logic [15:0] seen_addr = 16'h0000;
    always @(posedge clk_sys) begin
        if (ext_rd_n === 1'b0) rd_low <= rd_low + 1;
        if (ext_wr_n === 1'b0) wr_low <= wr_low + 1;
        if ((ext_rd_n & ext_wr_n) !== 1'b1) seen_addr <= ext_addr;
    end
endmodule

// >>> external_data_move_cycle_timing_test.sv
// self-checking bench for the machine cycle sequencer
`timescale 1ns/10ps
module external_data_move_cycle_timing_test;
    import external_data_move_timing_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        instr_valid = 1'b0;
    logic        sfr_wr = 1'b0;
    logic        sfr_inc = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [3:0]  decoded_cycles = 4'h1;
    logic [7:0]  indirect_index_register = 8'h00;
    logic [7:0]  port2_latch = 8'h00;
    logic [15:0] first_data_pointer = 16'h0000;
    logic [15:0] second_data_pointer = 16'h0000;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    mc_state_e   mc_state;
    logic        instr_taken;
    logic [3:0]  instr_cycles;
    logic        pointer_select_flag;
    logic [15:0] ext_addr;
    logic        ext_rd_n;
    logic        ext_wr_n;
    logic [31:0] rng = 32'h912F;
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [7:0]  mv_ops [6] = '{OP_READ_POINTER, OP_READ_INDIR0, OP_READ_INDIR1,
                                OP_WRITE_POINTER, OP_WRITE_INDIR0, OP_WRITE_INDIR1};
    always #4 clk_sys = ~clk_sys;
    external_data_move_cycle_timing u_external_data_move_cycle_timing (.clk_sys(clk_sys), .srst(srst),
        .instr_valid(instr_valid), .opcode(opcode), .decoded_cycles(decoded_cycles),
        .indirect_index_register(indirect_index_register), .port2_latch(port2_latch),
        .first_data_pointer(first_data_pointer), .second_data_pointer(second_data_pointer),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_inc(sfr_inc),
        .sfr_rdata(sfr_rdata), .mc_state(mc_state), .instr_taken(instr_taken),
        .instr_cycles(instr_cycles), .pointer_select_flag(pointer_select_flag),
        .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
    ext_mem u_ext_mem (.clk_sys(clk_sys), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [15:0] exp_width(input logic [2:0] s);
        return (s == 3'h0) ? 16'h0002 : {11'h000, s, 2'b00};
    endfunction
    function automatic logic [15:0] exp_plain(input logic [3:0] d);
        return (d < 4'h1) ? 16'h0001 : ((d > 4'h5) ? 16'h0005 : {12'h000, d});
    endfunction
    task automatic tally_and_finish;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic sfr_op(input logic [7:0] a, input logic [7:0] d, input logic w,
                          input logic i, output logic [7:0] got);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_inc <= i;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_inc <= 1'b0;
        @(posedge clk_sys);
        got = sfr_rdata;
    endtask
    task automatic run_instr(input logic [7:0] op, input logic [3:0] dc,
                             output logic [15:0] cyc, output logic [15:0] adr);
        int k;
        @(posedge clk_sys);
        opcode <= op;
        decoded_cycles <= dc;
        instr_valid <= 1'b1;
        for (k = 0; k < 200 && instr_taken !== 1'b1; k++) @(posedge clk_sys);
        instr_valid <= 1'b0;
        cyc = {12'h000, instr_cycles};
        adr = ext_addr;
        if (k == 200) begin
            n_mismatch++;
            $display("MISMATCH %0t instruction never taken", $time);
            tally_and_finish();
        end else begin
            repeat (40) @(posedge clk_sys);
        end
    endtask
    initial begin
        logic [7:0]  got;
        logic [7:0]  op;
        logic [15:0] cyc;
        logic [15:0] adr;
        logic [15:0] ea;
        logic [2:0]  s;
        logic        fl;
        int unsigned rd0;
        int unsigned wr0;
        s = 3'h1;
        fl = 1'b0;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        sfr_op(CLOCK_CONTROL_REGISTER_ADDR, 8'h00, 1'b0, 1'b0, got);
        cmp({8'h00, got}, 16'h0001, "stretch reset");
        sfr_op(DATA_POINTER_SELECT_ADDR, 8'hFE, 1'b1, 1'b0, got);
        cmp({8'h00, got}, 16'h0000, "select upper bits");
        sfr_op(8'h55, 8'hA5, 1'b1, 1'b0, got);
        cmp({8'h00, got}, 16'h0000, "unmapped read");
        for (int i = 0; i < 54; i++) begin
            if (i % 6 == 0 && i > 0) begin
                s = 3'(i / 6 - 1);
                sfr_op(CLOCK_CONTROL_REGISTER_ADDR, {rng[7:3], s}, 1'b1, 1'b0, got);
                cmp({8'h00, got}, {13'h0000, s}, "stretch field");
            end
            rng = xs(rng);
            sfr_op(DATA_POINTER_SELECT_ADDR, 8'h00, 1'b0, rng[0], got);
            fl = fl ^ rng[0];
            cmp({8'h00, got}, {15'h0000, fl}, "select flag");
            cmp({15'h0000, pointer_select_flag}, {15'h0000, fl}, "flag output");
            op = mv_ops[i % 6];
            first_data_pointer <= rng[31:16];
            second_data_pointer <= rng[15:0];
            indirect_index_register <= rng[23:16];
            port2_latch <= rng[11:4];
            ea = op[1] ? {rng[11:4], rng[23:16]} : (fl ? rng[15:0] : rng[31:16]);
            rd0 = u_ext_mem.rd_low;
            wr0 = u_ext_mem.wr_low;
            run_instr(op, rng[27:24], cyc, adr);
            cmp(cyc, 16'(s) + 16'h0002, "move length");
            cmp(adr, ea, "move address");
            cmp(16'(u_ext_mem.rd_low - rd0), op[4] ? 16'h0 : exp_width(s), "rd width");
            cmp(16'(u_ext_mem.wr_low - wr0), op[4] ? exp_width(s) : 16'h0, "wr width");
            cmp(u_ext_mem.seen_addr, ea, "far side address");
            rd0 = u_ext_mem.rd_low + u_ext_mem.wr_low;
            run_instr({1'b0, rng[30:24]}, rng[19:16], cyc, adr);
            cmp(cyc, exp_plain(rng[19:16]), "plain length");
            cmp(16'(u_ext_mem.rd_low + u_ext_mem.wr_low - rd0), 16'h0, "plain strobe");
        end
        tally_and_finish();
    end
endmodule
